// >>> verilog/mie_exec.sv
/*
  Executor of the data-move instructions: indirect move to the accumulator,
  literal loads of bank select, program counter high latch and accumulator, and accumulator store.
  Assumes a data memory that presents read data in the same cycle its read enable is high,
  and a core that issues a new command only while busy is low.
*/
// Function
// - Indirect move copies data reached through one of two pointers into accumulator.
// - Update code: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Relative form addresses pointer plus signed offset from -32 to 31.
// - Pointer ends one up or down; relative form leaves it unchanged.
// - Pre modes access the updated pointer; post modes access the old one.
// - Indirect window has no storage; accesses go to the pointed location.
// - Pointers are 16 bits and wrap at both ends.
// - Load bank literal writes 5-bit literal to bank select, flags unchanged.
// - Load pc high literal writes 7-bit literal to program counter high latch.
// - Load acc literal writes 8-bit literal to accumulator in one cycle.
// - Store acc writes accumulator to file register in one cycle, flags unchanged.
`timescale 1ns/1ps
module mie_exec (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instrValid,
  input wire mie_pkg::mie_cmd_t cmd,
  input wire logic ptrSel,
  input wire logic relForm,
  input wire logic [1:0] updCode,
  input wire logic [5:0] offset,
  input wire logic [7:0] literal,
  input wire logic [6:0] fileAddr,
  input wire logic [7:0] memRdData,
  output logic memRdEn,
  output logic memWrEn,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic [7:0] acc,
  output logic zeroFlag,
  output logic [4:0] bankSelect,
  output logic [6:0] pcHighLatch,
  output logic [15:0] pointer0,
  output logic [15:0] pointer1,
  output logic busy,
  output logic done
);
  typedef struct packed {
    mie_pkg::mie_phase_t phase;
    logic [7:0] acc;
    logic zero;
    logic [4:0] bank;
    logic [6:0] pch;
    logic [1:0][15:0] ptr;
    logic rdEn;
    logic wrEn;
    logic [15:0] addr;
    logic [7:0] wrData;
    logic busy;
    logic done;
  } mie_state_t;

  mie_state_t s_r;
  mie_state_t s_nxt;
  logic [15:0] effAddr;
  logic [15:0] ptrNext;
  logic take;
  logic windowHit;

  mie_ptr_calc u_calc (
    .ptrVal(s_r.ptr[ptrSel]),
    .relForm(relForm),
    .updCode(updCode),
    .offset(offset),
    .effAddr(effAddr),
    .ptrNext(ptrNext)
  );

  assign take = instrValid && (s_r.phase == mie_pkg::PH_IDLE);
  assign windowHit = (fileAddr == mie_pkg::WINDOW0_ADDR) || (fileAddr == mie_pkg::WINDOW1_ADDR);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdEn = 1'b0;
    s_nxt.wrEn = 1'b0;
    s_nxt.done = 1'b0;
    case (s_r.phase)
      mie_pkg::PH_IDLE: begin
        if (instrValid) begin
          case (cmd)
            mie_pkg::CMD_INDIRECT_MOVE_TO_ACC: begin
              s_nxt.rdEn = 1'b1;
              s_nxt.addr = effAddr;
              s_nxt.ptr[ptrSel] = ptrNext;
              s_nxt.busy = 1'b1;
              s_nxt.phase = mie_pkg::PH_READ;
            end
            mie_pkg::CMD_LOAD_BANK_LITERAL: begin
              s_nxt.bank = literal[4:0];
              s_nxt.done = 1'b1;
            end
            mie_pkg::CMD_LOAD_PC_HIGH_LITERAL: begin
              s_nxt.pch = literal[6:0];
              s_nxt.done = 1'b1;
            end
            mie_pkg::CMD_LOAD_ACC_LITERAL: begin
              s_nxt.acc = literal;
              s_nxt.done = 1'b1;
            end
            mie_pkg::CMD_STORE_ACC_TO_FILE: begin
              s_nxt.wrEn = 1'b1;
              s_nxt.wrData = s_r.acc;
              // The window is redirected, so it never needs a flop of its own
              if (windowHit) begin
                s_nxt.addr = s_r.ptr[fileAddr[0]];
              end else begin
                s_nxt.addr = {4'h0, s_r.bank, fileAddr};
              end
              s_nxt.done = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      mie_pkg::PH_READ: begin
        s_nxt.acc = memRdData;
        s_nxt.zero = (memRdData == 8'h00);
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.phase = mie_pkg::PH_IDLE;
      end
      default: begin
        s_nxt.phase = mie_pkg::PH_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{phase: mie_pkg::PH_IDLE, acc: mie_pkg::ACC_RST, zero: 1'b0, bank: mie_pkg::BANK_RST,
               pch: mie_pkg::PCH_RST, ptr: {mie_pkg::PTR_RST, mie_pkg::PTR_RST}, rdEn: 1'b0, wrEn: 1'b0,
               addr: mie_pkg::PTR_RST, wrData: mie_pkg::ACC_RST, busy: 1'b0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign memRdEn = s_r.rdEn;
  assign memWrEn = s_r.wrEn;
  assign memAddr = s_r.addr;
  assign memWrData = s_r.wrData;
  assign acc = s_r.acc;
  assign zeroFlag = s_r.zero;
  assign bankSelect = s_r.bank;
  assign pcHighLatch = s_r.pch;
  assign pointer0 = s_r.ptr[0];
  assign pointer1 = s_r.ptr[1];
  assign busy = s_r.busy;
  assign done = s_r.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic takeInd;
  logic takeBank;
  logic takePch;
  logic takeAcc;
  logic takeStore;
  assign takeInd = take && cmd == mie_pkg::CMD_INDIRECT_MOVE_TO_ACC;
  assign takeBank = take && cmd == mie_pkg::CMD_LOAD_BANK_LITERAL;
  assign takePch = take && cmd == mie_pkg::CMD_LOAD_PC_HIGH_LITERAL;
  assign takeAcc = take && cmd == mie_pkg::CMD_LOAD_ACC_LITERAL;
  assign takeStore = take && cmd == mie_pkg::CMD_STORE_ACC_TO_FILE;

  sequence s_readIssued;
    memRdEn && busy && !done;
  endsequence
  sequence s_readDone;
    done && !busy && !memRdEn && acc == $past(memRdData);
  endsequence

  property p_indMove;
    takeInd |=> s_readIssued ##1 s_readDone;
  endproperty
  a_indMove: assert property (p_indMove) else $error("indirect move did not load read data");

  property p_preAddr;
    takeInd && !relForm && !updCode[1] |=> memAddr == (updCode[0] ? $past(s_r.ptr[ptrSel]) - 16'h0001
                                                                   : $past(s_r.ptr[ptrSel]) + 16'h0001);
  endproperty
  a_preAddr: assert property (p_preAddr) else $error("pre mode address wrong");

  property p_postAddr;
    takeInd && !relForm && updCode[1] |=> memAddr == $past(s_r.ptr[ptrSel]);
  endproperty
  a_postAddr: assert property (p_postAddr) else $error("post mode address not old pointer");

  property p_relAddr;
    takeInd && relForm |=> memAddr == $past(s_r.ptr[ptrSel]) + {{10{$past(offset[5])}}, $past(offset)};
  endproperty
  a_relAddr: assert property (p_relAddr) else $error("relative address wrong");

  property p_ptrUpdate;
    takeInd && !relForm && ptrSel == 1'b0 |=> pointer0 == (updCode[0] ? $past(pointer0) - 16'h0001
                                                                      : $past(pointer0) + 16'h0001);
  endproperty
  a_ptrUpdate: assert property (p_ptrUpdate) else $error("pointer not stepped");

  property p_relKeep;
    takeInd && relForm |=> $stable(pointer0) && $stable(pointer1);
  endproperty
  a_relKeep: assert property (p_relKeep) else $error("relative form changed a pointer");

  property p_bank;
    takeBank |=> bankSelect == $past(literal[4:0]) && $stable(zeroFlag) && done;
  endproperty
  a_bank: assert property (p_bank) else $error("bank select load wrong");

  property p_pch;
    takePch |=> pcHighLatch == $past(literal[6:0]) && done;
  endproperty
  a_pch: assert property (p_pch) else $error("pc high latch load wrong");

  property p_accLit;
    takeAcc |=> acc == $past(literal) && done && !busy && $stable(zeroFlag);
  endproperty
  a_accLit: assert property (p_accLit) else $error("accumulator literal load wrong");

  property p_store;
    // A store taken right behind this one raises its own write, so only then may the strobe stay up
    takeStore |=> memWrEn && memWrData == $past(acc) && done && $stable(zeroFlag)
                  ##1 (!memWrEn || $past(takeStore));
  endproperty
  a_store: assert property (p_store) else $error("store not one cycle write of accumulator");

  property p_storeAddr;
    takeStore && !windowHit |=> memAddr == {4'h0, $past(bankSelect), $past(fileAddr)};
  endproperty
  a_storeAddr: assert property (p_storeAddr) else $error("store address not bank joined");

  property p_window;
    takeStore && fileAddr == mie_pkg::WINDOW1_ADDR |=> memAddr == $past(pointer1);
  endproperty
  a_window: assert property (p_window) else $error("window store not redirected");
endmodule : mie_exec

// >>> verilog/mie_pkg.sv
/*
  Shared constants and types of the data-move instruction executor.
  Assumes the core decoder has already turned the opcode into one command code and split out its operands.
*/
package mie_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_INDIRECT_MOVE_TO_ACC = 3'h1,
    CMD_LOAD_BANK_LITERAL = 3'h2,
    CMD_LOAD_PC_HIGH_LITERAL = 3'h3,
    CMD_LOAD_ACC_LITERAL = 3'h4,
    CMD_STORE_ACC_TO_FILE = 3'h5
  } mie_cmd_t;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_READ = 1'b1
  } mie_phase_t;

  // Pointer update codes
  localparam logic [1:0] UPD_PRE_INC = 2'h0;
  localparam logic [1:0] UPD_PRE_DEC = 2'h1;
  localparam logic [1:0] UPD_POST_INC = 2'h2;
  localparam logic [1:0] UPD_POST_DEC = 2'h3;

  localparam int PTR_W = 16;
  localparam int BANK_W = 5;
  localparam int PCH_W = 7;
  localparam int FILE_W = 7;
  localparam int DATA_W = 8;
  localparam int OFS_W = 6;

  // In-bank addresses of the two indirect windows
  localparam logic [6:0] WINDOW0_ADDR = 7'h00;
  localparam logic [6:0] WINDOW1_ADDR = 7'h01;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] BANK_RST = 5'h00;
  localparam logic [6:0] PCH_RST = 7'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] STEP_INC = 16'h0001;
  localparam logic [15:0] STEP_DEC = 16'hffff;
endpackage : mie_pkg

// >>> verilog/mie_ptr_calc.sv
/*
  Effective address and updated pointer for the indirect move.
  Purely combinational; the caller registers both results.
*/
`timescale 1ns/1ps
module mie_ptr_calc (
  input wire logic [15:0] ptrVal,
  input wire logic relForm,
  input wire logic [1:0] updCode,
  input wire logic [5:0] offset,
  output logic [15:0] effAddr,
  output logic [15:0] ptrNext
);
  logic [15:0] stepped;
  logic [15:0] relAddr;

  always_comb begin
    // 16-bit sums drop the carry, which gives the wraparound at both ends
    stepped = ptrVal + (updCode[0] ? mie_pkg::STEP_DEC : mie_pkg::STEP_INC);
    relAddr = ptrVal + {{10{offset[5]}}, offset};
    if (relForm) begin
      effAddr = relAddr;
      ptrNext = ptrVal;
    end else begin
      effAddr = updCode[1] ? ptrVal : stepped;
      ptrNext = stepped;
    end
  end
endmodule : mie_ptr_calc

// >>> tb/mie_exec_bench.sv
/*
  Self-checking bench of the data-move executor: a driver notes expected state per command,
  a watcher compares it when done pulses.
  Assumes the memory answers from memAddr in the cycle memRdEn is high.
*/
`timescale 1ns/1ps
module mie_exec_bench;
  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] bank;
    logic [6:0] pch;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [15:0] addr;
    logic z;
    logic st;
    logic mem;
  } mie_exp_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic instrValid = 1'b0;
  mie_pkg::mie_cmd_t cmd = mie_pkg::CMD_NOP;
  logic ptrSel = 1'b0;
  logic relForm = 1'b0;
  logic [1:0] updCode = 2'h0;
  logic [5:0] offset = 6'h00;
  logic [7:0] literal = 8'h00;
  logic [6:0] fileAddr = 7'h00;
  logic [7:0] memRdData = 8'h00;
  logic memRdEn, memWrEn, zeroFlag, busy, done;
  logic [15:0] memAddr, pointer0, pointer1;
  logic [7:0] memWrData, acc;
  logic [4:0] bankSelect;
  logic [6:0] pcHighLatch;
  int nMismatch = 0;
  int nCompared = 0;
  logic [31:0] seed = 32'ha99cba14;
  mie_exp_t m;
  mie_exp_t e;
  mie_exp_t q[$];
  logic [31:0] v;

  mie_exec DUT (.clk(clk), .rstn(rstn), .instrValid(instrValid), .cmd(cmd), .ptrSel(ptrSel), .relForm(relForm),
    .updCode(updCode), .offset(offset), .literal(literal), .fileAddr(fileAddr), .memRdData(memRdData),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData), .acc(acc),
    .zeroFlag(zeroFlag), .bankSelect(bankSelect), .pcHighLatch(pcHighLatch), .pointer0(pointer0),
    .pointer1(pointer1), .busy(busy), .done(done));

  always #10 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Address 0 reads as zero, so the zero flag gets exercised
  function automatic logic [7:0] memf(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : memf

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic doReset();
    @(negedge clk);
    rstn = 1'b0;
    instrValid = 1'b0;
    repeat (4) @(negedge clk);
    chk({bankSelect, pcHighLatch, done, busy, memRdEn, memWrEn}, 16'h0000);
    chk({acc, memWrData}, 16'h0000);
    chk(memAddr, 16'h0000);
    chk(pointer0 | pointer1 | {15'h0000, zeroFlag}, mie_pkg::PTR_RST);
    m = '0;
    q.delete();
    rstn = 1'b1;
  endtask : doReset

  task automatic issue(input mie_pkg::mie_cmd_t c, input logic s, input logic r, input logic [1:0] u,
                       input logic [5:0] o, input logic [7:0] l, input logic [6:0] f);
    logic [15:0] p;
    logic [15:0] np;
    @(negedge clk);
    cmd = c;
    ptrSel = s;
    relForm = r;
    updCode = u;
    offset = o;
    literal = l;
    fileAddr = f;
    instrValid = 1'b1;
    p = s ? m.p1 : m.p0;
    m.st = 1'b0;
    m.mem = 1'b0;
    case (c)
      mie_pkg::CMD_INDIRECT_MOVE_TO_ACC: begin
        np = u[0] ? p + mie_pkg::STEP_DEC : p + mie_pkg::STEP_INC;
        m.addr = u[1] ? p : np;
        if (r) begin
          np = p;
          m.addr = p + {{10{o[5]}}, o};
        end
        if (s) m.p1 = np;
        else m.p0 = np;
        m.acc = memf(m.addr);
        m.z = (m.acc == 8'h00);
        m.mem = 1'b1;
      end
      mie_pkg::CMD_LOAD_BANK_LITERAL: m.bank = l[4:0];
      mie_pkg::CMD_LOAD_PC_HIGH_LITERAL: m.pch = l[6:0];
      mie_pkg::CMD_LOAD_ACC_LITERAL: m.acc = l;
      mie_pkg::CMD_STORE_ACC_TO_FILE: begin
        if (f == mie_pkg::WINDOW0_ADDR) m.addr = m.p0;
        else if (f == mie_pkg::WINDOW1_ADDR) m.addr = m.p1;
        else m.addr = {4'h0, m.bank, f};
        m.st = 1'b1;
        m.mem = 1'b1;
      end
      default: ;
    endcase
    if (c != mie_pkg::CMD_NOP && c <= mie_pkg::CMD_STORE_ACC_TO_FILE) q.push_back(m);
    // Idle through the read cycle so the next command never lands while busy
    if (c == mie_pkg::CMD_INDIRECT_MOVE_TO_ACC) begin
      @(negedge clk);
      instrValid = 1'b0;
      @(negedge clk);
    end
  endtask : issue

  always @(negedge clk) begin
    memRdData <= (memRdEn === 1'b1) ? memf(memAddr) : rnd();
    if (rstn === 1'b1 && done === 1'b1) begin
      if (q.size() == 0) chk(16'h0001, 16'h0000);
      else begin
        e = q.pop_front();
        chk(acc, e.acc);
        chk(bankSelect, e.bank);
        chk(pcHighLatch, e.pch);
        chk(pointer0, e.p0);
        chk(pointer1, e.p1);
        chk(zeroFlag, e.z);
        chk(memWrEn, e.st);
        if (e.mem) chk(memAddr, e.addr);
        if (e.st) chk(memWrData, e.acc);
      end
    end
  end

  initial begin
    #400000;
    nMismatch++;
    conclude();
  end

  initial begin
    doReset();
    issue(mie_pkg::CMD_INDIRECT_MOVE_TO_ACC, 1'b0, 1'b0, 2'h1, 6'h00, 8'h00, 7'h00);
    issue(mie_pkg::CMD_INDIRECT_MOVE_TO_ACC, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00, 7'h00);
    issue(mie_pkg::CMD_INDIRECT_MOVE_TO_ACC, 1'b1, 1'b0, 2'h3, 6'h00, 8'h00, 7'h00);
    issue(mie_pkg::CMD_INDIRECT_MOVE_TO_ACC, 1'b1, 1'b0, 2'h2, 6'h00, 8'h00, 7'h00);
    issue(mie_pkg::CMD_INDIRECT_MOVE_TO_ACC, 1'b0, 1'b1, 2'h0, 6'h20, 8'h00, 7'h00);
    issue(mie_pkg::CMD_INDIRECT_MOVE_TO_ACC, 1'b1, 1'b1, 2'h1, 6'h1f, 8'h00, 7'h00);
    $display("test pointer modes done");
    for (int i = 0; i < 2; i++) begin
      v = i ? 32'hffffffff : 32'h0;
      issue(mie_pkg::CMD_LOAD_BANK_LITERAL, 1'b0, 1'b0, 2'h0, 6'h00, v[7:0], 7'h00);
      issue(mie_pkg::CMD_LOAD_PC_HIGH_LITERAL, 1'b0, 1'b0, 2'h0, 6'h00, v[7:0], 7'h00);
      issue(mie_pkg::CMD_LOAD_ACC_LITERAL, 1'b0, 1'b0, 2'h0, 6'h00, v[7:0] ^ 8'h5a, 7'h00);
      issue(mie_pkg::CMD_STORE_ACC_TO_FILE, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00, v[6:0]);
      issue(mie_pkg::CMD_STORE_ACC_TO_FILE, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00, {6'h00, ~v[0]});
    end
    // Codes 0, 6 and 7 must be ignored: any done pulse then finds an empty queue
    for (int c = 0; c < 3; c++) begin
      v = c;
      issue(mie_pkg::mie_cmd_t'(v[1:0] == 2'h0 ? 3'h0 : 3'h5 + v[2:0]), 1'b0, 1'b0, 2'h0, 6'h00, 8'h11, 7'h05);
    end
    $display("test literal and store done");
    for (int i = 0; i < 400; i++) begin
      v = rnd();
      issue(mie_pkg::mie_cmd_t'(v[2:0] % 3'h5 + 3'h1), v[3], v[4], v[6:5], v[12:7], v[20:13], v[27:21]);
    end
    $display("test random mix done");
    doReset();
    issue(mie_pkg::CMD_INDIRECT_MOVE_TO_ACC, 1'b1, 1'b0, 2'h0, 6'h00, 8'h00, 7'h00);
    @(negedge clk);
    instrValid = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(q.size()), 16'h0000);
    $display("test reset rerun done");
    conclude();
  end
endmodule : mie_exec_bench
